/* File: src/pmwu_map.svh */
// Constants of the power mode wake unit: mode codes, wake source positions and timing counts.
`ifndef PMWU_MAP_SVH
`define PMWU_MAP_SVH

// ****************************************************************
// Mode request codes
// ****************************************************************
`define PMWU_REQ_NONE     3'h0
`define PMWU_REQ_IDLE     3'h1
`define PMWU_REQ_STOP     3'h2
`define PMWU_REQ_SUSPEND  3'h3
`define PMWU_REQ_SLEEP    3'h4

// ****************************************************************
// Wake source bit positions
// ****************************************************************
`define PMWU_WK_CAPSENSE  0
`define PMWU_WK_RTC       1
`define PMWU_WK_PORTMATCH 2
`define PMWU_WK_COMPARE   3
`define PMWU_WK_RESETPIN  4
`define PMWU_WK_WIDTH     5

// ****************************************************************
// Timing
// ****************************************************************
`define PMWU_CLK_MHZ          20
`define PMWU_OSC_SETTLE_NS    200
`define PMWU_OSC_SETTLE_CYC   ((`PMWU_OSC_SETTLE_NS * `PMWU_CLK_MHZ + 999) / 1000)
`define PMWU_SUPPLY_SETTLE_NS 500
`define PMWU_SUPPLY_SETTLE_CYC ((`PMWU_SUPPLY_SETTLE_NS * `PMWU_CLK_MHZ + 999) / 1000)
`define PMWU_CNT_WIDTH        8
`define PMWU_CNT_ZERO         8'h00
`define PMWU_CNT_ONE          8'h01

`endif

/* File: src/pmwu_pkg.sv */
// Types of the power mode wake unit.
package pmwu_pkg;

	// ****************************************************************
	// Power mode state, Gray coded along entry, hold, restore.
	// ****************************************************************
	typedef enum logic [3:0] {
		PMWU_NORMAL     = 4'h0,
		PMWU_IDLE       = 4'h1,
		PMWU_STOP       = 4'h3,
		PMWU_SUSPEND    = 4'h2,
		PMWU_SLEEP      = 4'h6,
		PMWU_RESTORE    = 4'h7,
		PMWU_RESUME     = 4'h5
	} pmwu_state_t;

	// Gating controls sent to the rest of the chip.
	typedef struct packed {
		logic cpuRun;
		logic periphClkOn;
		logic precisionOscOn;
		logic lowPowerOscOn;
		logic sysClkOn;
		logic coreSupplyOn;
		logic rtcOscOn;
		logic compareOn;
	} pmwu_gate_t;

	// Raw wake events from the chip's wake sources.
	typedef struct packed {
		logic resetPin;
		logic compare;
		logic portMatch;
		logic rtc;
		logic capSense;
	} pmwu_wake_t;

endpackage : pmwu_pkg

/* File: src/pmwu_sync.sv */
// Two-flop synchroniser for a vector of asynchronous wake inputs.
module pmwu_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	// ****************************************************************
	// Synchroniser chain
	// ****************************************************************
	// One chain per bit; the first stage feeds only the second.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gChain
			always_ff @(posedge clk) begin
				if (reset) begin
					stage1_reg[i] <= 1'b0;
					stage2_reg[i] <= 1'b0;
				end else begin
					stage1_reg[i] <= asyncIn[i];
					stage2_reg[i] <= stage1_reg[i];
				end
			end
		end
	endgenerate

	assign syncOut = stage2_reg;

endmodule : pmwu_sync

/* File: src/pmwu_power_manager.sv */
// Power manager: mode entry, clock and supply gating, and wake-up sequencing.
// Behaviour
// - Four low-power modes, entry for each, wake for all but stop.
// - Idle halts code; peripherals run; interrupts wake.
// - Stop ends only through a reset.
// - Stop: no code, precision oscillator off.
// - Suspend wakes on five sources, resumes next.
// - Suspend: all internal oscillators off, clock gated.
// - Sleep wakes on four sources, resumes next.
// - Sleep: core supply off, only RTC oscillator.
// - Sleep comparator works only in two-cell mode.
// - Sleep: digital peripherals draw no power.
`include "pmwu_map.svh"

module pmwu_power_manager (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic [2:0]           modeReq,
	input  wire logic                 modeReqValid,
	input  wire logic                 anyInterrupt,
	input  wire pmwu_pkg::pmwu_wake_t wakeRaw,
	input  wire logic                 twoCellMode,
	output pmwu_pkg::pmwu_gate_t      gate,
	output pmwu_pkg::pmwu_state_t     mode,
	output logic                      resumeStrobe,
	output logic                      wakeFromRestart,
	output pmwu_pkg::pmwu_wake_t      wakeCause
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	pmwu_pkg::pmwu_state_t                state_reg;
	pmwu_pkg::pmwu_state_t                state_next;
	pmwu_pkg::pmwu_state_t                lowMode_reg;
	pmwu_pkg::pmwu_state_t                lowMode_next;
	logic [`PMWU_CNT_WIDTH-1:0]           settle_reg;
	logic [`PMWU_CNT_WIDTH-1:0]           settle_next;
	pmwu_pkg::pmwu_gate_t                 gate_reg;
	pmwu_pkg::pmwu_gate_t                 gate_next;
	pmwu_pkg::pmwu_wake_t                 cause_reg;
	pmwu_pkg::pmwu_wake_t                 cause_next;
	logic                                 resume_reg;
	logic                                 resume_next;
	logic                                 twoCell_reg;
	logic                                 twoCellNext;
	logic                                 restart_reg;
	logic                                 restart_next;
	logic [`PMWU_WK_WIDTH-1:0]            wakeSyncVec;
	pmwu_pkg::pmwu_wake_t                 wakeSync;
	pmwu_pkg::pmwu_wake_t                 suspendWake;
	pmwu_pkg::pmwu_wake_t                 sleepWake;
	logic                                 suspendHit;
	logic                                 sleepHit;
	logic                                 idleHit;
	logic                                 reqIdle;
	logic                                 reqStop;
	logic                                 reqSuspend;
	logic                                 reqSleep;
	logic [`PMWU_CNT_WIDTH-1:0]           settleLoad;

	// Settle counts cut to the counter width once, here.
	// A settle time above 255 cycles would need a wider counter.
	localparam logic [`PMWU_CNT_WIDTH-1:0] OSC_SETTLE =
		`PMWU_CNT_WIDTH'(`PMWU_OSC_SETTLE_CYC);
	localparam logic [`PMWU_CNT_WIDTH-1:0] SUPPLY_SETTLE =
		`PMWU_CNT_WIDTH'(`PMWU_SUPPLY_SETTLE_CYC);

	// ****************************************************************
	// Gating function
	// ****************************************************************
	// Maps a state to its clock and supply gating; used for the next
	// value only; reset loads all ones, which matches normal.
	function automatic pmwu_pkg::pmwu_gate_t gateFor(
		input pmwu_pkg::pmwu_state_t st,
		input logic                  twoCell
	);
		pmwu_pkg::pmwu_gate_t g;
		g = '{cpuRun: 1'b1, periphClkOn: 1'b1, precisionOscOn: 1'b1,
			lowPowerOscOn: 1'b1, sysClkOn: 1'b1, coreSupplyOn: 1'b1,
			rtcOscOn: 1'b1, compareOn: 1'b1};
		case (st)
			pmwu_pkg::PMWU_NORMAL: begin
				g.cpuRun = 1'b1;
			end
			pmwu_pkg::PMWU_IDLE: begin
				g.cpuRun = 1'b0;
			end
			pmwu_pkg::PMWU_STOP: begin
				// Peripherals halt too, as in the legacy low-power mode.
				g.cpuRun         = 1'b0;
				g.precisionOscOn = 1'b0;
				g.periphClkOn    = 1'b0;
			end
			pmwu_pkg::PMWU_SUSPEND: begin
				g.cpuRun         = 1'b0;
				g.precisionOscOn = 1'b0;
				g.lowPowerOscOn  = 1'b0;
				g.sysClkOn       = 1'b0;
				g.periphClkOn    = 1'b0;
			end
			pmwu_pkg::PMWU_SLEEP: begin
				g.cpuRun         = 1'b0;
				g.precisionOscOn = 1'b0;
				g.lowPowerOscOn  = 1'b0;
				g.sysClkOn       = 1'b0;
				g.periphClkOn    = 1'b0;
				g.coreSupplyOn   = 1'b0;
				g.rtcOscOn       = 1'b1;
				// The comparator keeps running only where it may wake the device.
				g.compareOn      = twoCell;
			end
			pmwu_pkg::PMWU_RESTORE: begin
				g.cpuRun = 1'b0;
			end
			pmwu_pkg::PMWU_RESUME: begin
				g.cpuRun = 1'b0;
			end
			default: begin
				g.cpuRun = 1'b1;
			end
		endcase
		return g;
	endfunction : gateFor

	// ****************************************************************
	// Wake input synchronisers
	// ****************************************************************
	// Wake events arrive from pins and other blocks, so all pass two flops.
	// The two flops add two cycles of wake latency in suspend and sleep.
	pmwu_sync #(
		.WIDTH(`PMWU_WK_WIDTH)
	) uSync (
		.clk    (clk),
		.reset  (reset),
		.asyncIn(wakeRaw),
		.syncOut(wakeSyncVec)
	);

	assign wakeSync = pmwu_pkg::pmwu_wake_t'(wakeSyncVec);

	// ****************************************************************
	// Request and wake decoding
	// ****************************************************************
	// Codes outside one to four decode to no request and are dropped.
	assign reqIdle    = modeReqValid && (modeReq == `PMWU_REQ_IDLE);
	assign reqStop    = modeReqValid && (modeReq == `PMWU_REQ_STOP);
	assign reqSuspend = modeReqValid && (modeReq == `PMWU_REQ_SUSPEND);
	assign reqSleep   = modeReqValid && (modeReq == `PMWU_REQ_SLEEP);

	// Suspend listens to all five sources.
	assign suspendWake = wakeSync;
	assign suspendHit  = |suspendWake;

	// Sleep ignores capacitive sense; the comparator counts only with two cells.
	assign sleepWake = '{resetPin: wakeSync.resetPin,
		compare: wakeSync.compare & twoCell_reg,
		portMatch: wakeSync.portMatch,
		rtc: wakeSync.rtc,
		capSense: 1'b0};
	assign sleepHit = |sleepWake;

	// Interrupts come from logic on this clock, so no synchroniser.
	// An interrupt already pending at the idle request wakes a cycle later.
	assign idleHit = anyInterrupt;

	// Leaving sleep waits for the supply, leaving suspend only the oscillators.
	assign settleLoad = (lowMode_reg == pmwu_pkg::PMWU_SLEEP) ? SUPPLY_SETTLE : OSC_SETTLE;

	// The gating and the wake mask take the supply mode from one value, so
	// the comparator enable and its wake qualifier agree even when the level
	// moves in the very cycle of the sleep request.
	assign twoCellNext = (state_reg == pmwu_pkg::PMWU_NORMAL) ? twoCellMode
		: twoCell_reg;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_next   = state_reg;
		lowMode_next = lowMode_reg;
		settle_next  = settle_reg;
		cause_next   = cause_reg;
		resume_next  = 1'b0;
		case (state_reg)
			pmwu_pkg::PMWU_NORMAL: begin
				if (reqIdle) begin
					state_next = pmwu_pkg::PMWU_IDLE;
				end else if (reqStop) begin
					state_next = pmwu_pkg::PMWU_STOP;
				end else if (reqSuspend) begin
					state_next   = pmwu_pkg::PMWU_SUSPEND;
					lowMode_next = pmwu_pkg::PMWU_SUSPEND;
				end else if (reqSleep) begin
					state_next   = pmwu_pkg::PMWU_SLEEP;
					lowMode_next = pmwu_pkg::PMWU_SLEEP;
				end
			end
			pmwu_pkg::PMWU_IDLE: begin
				// Clocks never stopped, so code resumes at once.
				if (idleHit) begin
					state_next  = pmwu_pkg::PMWU_NORMAL;
					resume_next = 1'b1;
				end
			end
			pmwu_pkg::PMWU_STOP: begin
				// Deliberately no exit: only the reset input leaves stop.
				state_next = pmwu_pkg::PMWU_STOP;
			end
			pmwu_pkg::PMWU_SUSPEND: begin
				if (suspendHit) begin
					state_next  = pmwu_pkg::PMWU_RESTORE;
					cause_next  = suspendWake;
					settle_next = settleLoad;
				end
			end
			pmwu_pkg::PMWU_SLEEP: begin
				if (sleepHit) begin
					state_next  = pmwu_pkg::PMWU_RESTORE;
					cause_next  = sleepWake;
					settle_next = settleLoad;
				end
			end
			pmwu_pkg::PMWU_RESTORE: begin
				// Clocks and supply run again; hold code until they settle.
				if (settle_reg <= `PMWU_CNT_ONE) begin
					state_next  = pmwu_pkg::PMWU_RESUME;
					settle_next = `PMWU_CNT_ZERO;
				end else begin
					settle_next = settle_reg - `PMWU_CNT_ONE;
				end
			end
			pmwu_pkg::PMWU_RESUME: begin
				// One cycle with clocks running and code held lets the gating settle.
				state_next   = pmwu_pkg::PMWU_NORMAL;
				lowMode_next = pmwu_pkg::PMWU_NORMAL;
				resume_next  = 1'b1;
			end
			default: begin
				state_next = pmwu_pkg::PMWU_NORMAL;
			end
		endcase
		gate_next = gateFor(state_next, twoCellNext);
	end

	// The restore flag comes from a flip-flop like the other status outputs.
	assign restart_next = (state_next == pmwu_pkg::PMWU_RESTORE);

	// ****************************************************************
	// State registers
	// ****************************************************************
	// Reset is the only way out of stop, and it lands in normal.
	// A reset in any mode clears the remembered low-power mode as well.
	always_ff @(posedge clk) begin
		if (reset) begin
			restart_reg <= 1'b0;
			state_reg   <= pmwu_pkg::PMWU_NORMAL;
			lowMode_reg <= pmwu_pkg::PMWU_NORMAL;
			settle_reg  <= `PMWU_CNT_ZERO;
			cause_reg   <= '0;
			resume_reg  <= 1'b0;
		end else begin
			restart_reg <= restart_next;
			state_reg   <= state_next;
			lowMode_reg <= lowMode_next;
			settle_reg  <= settle_next;
			cause_reg   <= cause_next;
			resume_reg  <= resume_next;
		end
	end

	// Gating outputs are registered so the rest of the chip sees no glitches.
	always_ff @(posedge clk) begin
		if (reset) begin
			gate_reg <= '1;
		end else begin
			gate_reg <= gate_next;
		end
	end

	// Supply mode is a configuration level; it is sampled only in normal
	// so it cannot shift under a sleeping comparator.
	always_ff @(posedge clk) begin
		if (reset) begin
			twoCell_reg <= 1'b0;
		end else begin
			twoCell_reg <= twoCellNext;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Mode is the raw state code, so restore and resume show on it too.
	assign gate            = gate_reg;
	assign mode            = state_reg;
	assign resumeStrobe    = resume_reg;
	assign wakeCause       = cause_reg;
	assign wakeFromRestart = restart_reg;

endmodule : pmwu_power_manager

/* File: verification/pmwu_power_manager_assertions.sv */
// Concurrent checks on the ports of the power manager, bound into its top.
module pmwu_checker (
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic [2:0]            modeReq,
	input wire logic                  modeReqValid,
	input wire logic                  anyInterrupt,
	input wire pmwu_pkg::pmwu_wake_t  wakeRaw,
	input wire logic                  twoCellMode,
	input wire pmwu_pkg::pmwu_gate_t  gate,
	input wire pmwu_pkg::pmwu_state_t mode,
	input wire logic                  resumeStrobe,
	input wire logic                  wakeFromRestart,
	input wire pmwu_pkg::pmwu_wake_t  wakeCause
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Checks
	// ****************************************************************
	// One clock domain, so the clock and reset are given once for all.
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Wake latency allows two synchroniser flops plus the state edge.
	chk_req_taken: assert property (mode == pmwu_pkg::PMWU_NORMAL && modeReqValid
		&& modeReq == 3'h3 |=> mode == pmwu_pkg::PMWU_SUSPEND) else $error("suspend not entered");
	chk_idle_gating: assert property (mode == pmwu_pkg::PMWU_IDLE
		|-> !gate.cpuRun && gate.periphClkOn) else $error("idle gating wrong");
	chk_idle_wake: assert property (mode == pmwu_pkg::PMWU_IDLE && anyInterrupt
		|=> mode == pmwu_pkg::PMWU_NORMAL && resumeStrobe) else $error("idle did not wake");
	chk_stop_holds: assert property (mode == pmwu_pkg::PMWU_STOP
		|=> mode == pmwu_pkg::PMWU_STOP) else $error("stop left without reset");
	chk_stop_gating: assert property (mode == pmwu_pkg::PMWU_STOP
		|-> !gate.cpuRun && !gate.precisionOscOn) else $error("stop gating wrong");
	chk_susp_wake: assert property (mode == pmwu_pkg::PMWU_SUSPEND && wakeRaw != 5'h00
		|-> ##[1:5] mode == pmwu_pkg::PMWU_RESTORE) else $error("suspend did not wake");
	chk_susp_gating: assert property (mode == pmwu_pkg::PMWU_SUSPEND
		|-> !gate.precisionOscOn && !gate.lowPowerOscOn && !gate.sysClkOn)
		else $error("suspend gating wrong");
	chk_sleep_wake: assert property (mode == pmwu_pkg::PMWU_SLEEP
		&& (wakeRaw.rtc || wakeRaw.portMatch || wakeRaw.resetPin)
		|-> ##[1:5] mode == pmwu_pkg::PMWU_RESTORE) else $error("sleep did not wake");
	chk_sleep_gating: assert property (mode == pmwu_pkg::PMWU_SLEEP
		|-> !gate.coreSupplyOn && gate.rtcOscOn && !gate.precisionOscOn
		&& !gate.lowPowerOscOn && !gate.periphClkOn) else $error("sleep gating wrong");
	chk_clock_first: assert property (mode == pmwu_pkg::PMWU_RESUME
		|-> gate.sysClkOn && gate.precisionOscOn && !gate.cpuRun) else $error("code before clock");
	chk_resume_back: assert property (resumeStrobe |-> mode == pmwu_pkg::PMWU_NORMAL
		&& gate.cpuRun && ($past(mode) == pmwu_pkg::PMWU_RESUME
		|| $past(mode) == pmwu_pkg::PMWU_IDLE)) else $error("resume path wrong");
	chk_restart_flag: assert property (wakeFromRestart
		|-> !gate.cpuRun && gate.sysClkOn && !resumeStrobe) else $error("restore flag wrong");

	cover property (mode == pmwu_pkg::PMWU_IDLE ##1 resumeStrobe);
	cover property (mode == pmwu_pkg::PMWU_SUSPEND ##[1:5] mode == pmwu_pkg::PMWU_RESTORE);
	cover property (mode == pmwu_pkg::PMWU_SLEEP ##[1:5] mode == pmwu_pkg::PMWU_RESTORE);
endmodule : pmwu_checker

bind pmwu_power_manager pmwu_checker u_pmwu_checker (.clk(clk), .reset(reset),
	.modeReq(modeReq), .modeReqValid(modeReqValid), .anyInterrupt(anyInterrupt),
	.wakeRaw(wakeRaw), .twoCellMode(twoCellMode), .gate(gate), .mode(mode),
	.resumeStrobe(resumeStrobe), .wakeFromRestart(wakeFromRestart), .wakeCause(wakeCause));

/* File: verification/pmwu_testbench.sv */
// Self-checking testbench of the power manager.
`include "pmwu_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic [2:0]            modeReq = 3'h0;
	logic                  modeReqValid = 1'b0;
	logic                  anyInterrupt = 1'b0;
	pmwu_pkg::pmwu_wake_t  wakeRaw = 5'h00;
	logic                  twoCellMode = 1'b0;
	pmwu_pkg::pmwu_gate_t  gate;
	pmwu_pkg::pmwu_state_t mode;
	logic                  resumeStrobe;
	logic                  wakeFromRestart;
	pmwu_pkg::pmwu_wake_t  wakeCause;
	int                    err_total = 0;
	int                    compares = 0;
	logic                  woke;

	pmwu_power_manager u_pmwu_power_manager (.clk(clk), .reset(reset), .modeReq(modeReq),
		.modeReqValid(modeReqValid), .anyInterrupt(anyInterrupt), .wakeRaw(wakeRaw),
		.twoCellMode(twoCellMode), .gate(gate), .mode(mode), .resumeStrobe(resumeStrobe),
		.wakeFromRestart(wakeFromRestart), .wakeCause(wakeCause));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// A 50 ns clock period.
	always #25 clk = ~clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	// Idle cycles first, so stale synchronised wake bits drain before a new entry.
	task automatic req(input logic [2:0] code);
		repeat (3) @(posedge clk);
		modeReqValid <= 1'b1;
		modeReq <= code;
		@(posedge clk);
		modeReqValid <= 1'b0;
		#1;
	endtask : req

	// Holds one wake source up until code resumes, or gives up after 30 cycles;
	// the restore cycles counted on the way must equal the mode's settle time.
	task automatic wakeOn(input int idx, input int settle);
		int restoreCycles = 0;
		@(posedge clk);
		wakeRaw <= pmwu_pkg::pmwu_wake_t'(5'h01 << idx);
		woke = 1'b0;
		for (int n = 0; n < 30 && !woke; n++) begin
			@(posedge clk);
			#1;
			woke = (resumeStrobe === 1'b1);
			restoreCycles += (wakeFromRestart === 1'b1) ? 1 : 0;
		end
		if (woke) chk(8'({gate.cpuRun, gate.sysClkOn, mode}), 8'h30);
		chk(8'(restoreCycles), woke ? 8'(settle) : 8'h00);
		@(posedge clk);
		wakeRaw <= 5'h00;
	endtask : wakeOn

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_idle;
		for (int c = 5; c < 9; c++) begin
			req(3'(c));
			chk(8'(mode), 8'(pmwu_pkg::PMWU_NORMAL));
		end
		req(3'h1);
		chk(8'({mode, gate.cpuRun, gate.periphClkOn}), 8'h05);
		req(3'h3);
		chk(8'(mode), 8'(pmwu_pkg::PMWU_IDLE));
		@(posedge clk);
		anyInterrupt <= 1'b1;
		@(posedge clk);
		anyInterrupt <= 1'b0;
		#1;
		chk(8'({mode, resumeStrobe, gate.cpuRun}), 8'h03);
		$display("test idle done");
	endtask : test_idle

	task automatic test_stop;
		req(3'h2);
		chk(8'({mode, gate.cpuRun, gate.precisionOscOn}), 8'h0c);
		@(posedge clk);
		anyInterrupt <= 1'b1;
		wakeRaw <= pmwu_pkg::pmwu_wake_t'(5'h1f);
		repeat (12) @(posedge clk);
		#1;
		chk(8'(mode), 8'(pmwu_pkg::PMWU_STOP));
		@(posedge clk);
		anyInterrupt <= 1'b0;
		wakeRaw <= 5'h00;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(8'(mode), 8'(pmwu_pkg::PMWU_NORMAL));
		chk(8'(gate), 8'hff);
		$display("test stop done");
	endtask : test_stop

	task automatic test_suspend;
		for (int i = 0; i < 5; i++) begin
			req(3'h3);
			chk(8'({gate.precisionOscOn, gate.lowPowerOscOn, gate.sysClkOn}), 8'h00);
			wakeOn(i, `PMWU_OSC_SETTLE_CYC);
			chk(8'(woke), 8'h01);
			chk(8'(wakeCause), 8'(5'h01 << i));
		end
		$display("test suspend done");
	endtask : test_suspend

	// The supply mode is flipped inside sleep: only the value held in normal counts.
	task automatic test_sleep;
		int   src [6] = '{0, 1, 2, 3, 3, 4};
		logic tc  [6] = '{0, 0, 0, 0, 1, 0};
		logic ok  [6] = '{0, 1, 1, 0, 1, 1};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			twoCellMode <= tc[i];
			req(3'h4);
			chk(8'({gate.coreSupplyOn, gate.precisionOscOn}), 8'h00);
			chk(8'({gate.lowPowerOscOn, gate.rtcOscOn}), 8'h01);
			chk(8'({gate.periphClkOn, gate.cpuRun}), 8'h00);
			chk(8'(gate.compareOn), 8'(tc[i]));
			@(posedge clk);
			twoCellMode <= !tc[i];
			wakeOn(src[i], `PMWU_SUPPLY_SETTLE_CYC);
			chk(8'(woke), 8'(ok[i]));
			if (!woke) begin
				wakeOn(1, `PMWU_SUPPLY_SETTLE_CYC);
				chk(8'(wakeCause), 8'h02);
			end else begin
				chk(8'(wakeCause), 8'(5'h01 << src[i]));
			end
		end
		$display("test sleep done");
	endtask : test_sleep

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		test_idle;
		test_stop;
		test_suspend;
		test_sleep;
		end_sim;
	end

	// The scenarios need well under a thousand cycles.
	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		end_sim;
	end
endmodule : testbench
